// ==== sel_pkg.sv ====
// Constants and types for the two-wire management block of the repeater.
// Assumes a pad comparator that codes the mode strap level into two bits.
//
// Contract
// [RULE1] Strap 0000 answers address byte B0, 7-bit address 58, bit 0 write.
// [RULE2] Address strap pads pull down, so a floating strap reads 0000.
// [RULE3] Sixteen slave addresses: 58 plus the 4-bit strap, 58 to 67.
// [RULE4] Slave mode and register access only when mode strap is high.
// [RULE5] The data line changes only while the clock line is low.
// [RULE6] Data falling while clock high is a start condition.
// [RULE7] Data rising while clock high is a stop ending the message.
// [RULE8] Both lines high beyond the idle time puts the bus idle.
// [RULE9] Write: address, register pointer, one data byte, each acknowledged.
// [RULE10] Read: pointer write, repeated start, read address, one byte, NACK.
// [RULE11] Floating mode strap makes the device master and load from EEPROM.
// [RULE12] The EEPROM is addressed with byte A0 at 1 MHz.
// [RULE13] First three EEPROM bytes: header with CRC, map and size flags.
// [RULE14] Without the map flag, data starts right after the header; the code ignores the map flag and offsets data by the two low address strap bits.
// [RULE15] The loader reads 37 data bytes per device.
// [RULE16] EEPROMs of up to 1024 bytes are addressed.
// [RULE17] CRC-8, polynomial x^8+x^2+x+1, over header plus data, 40 bytes.
// [RULE18] The stored CRC byte follows the device data directly.
// [RULE19] Master waits for low load enable before taking the bus.
// [RULE20] Done output goes low when the load has finished.
// [RULE21] System chains done outputs into the next load enable inputs.
// [RULE22] Per-device data blocks are aligned from EEPROM byte 03.
// [RULE23] Mode strap: low pin control, high slave, floating master.
// [RULE24] Registers return to defaults at reset and while strap is low.
// [RULE25] After loading, both bus lines are released.

package sel_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_NS = 20;
  localparam int LINK_PERIOD_NS = 32;
  localparam int EE_PERIOD_NS = 1000;
  localparam int EE_QTR_CYC =
    (EE_PERIOD_NS / 4 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int IDLE_NS = 50000;
  localparam int IDLE_CYC = (IDLE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Addresses and image layout
  // ----------------------------------------------------------------
  localparam logic [6:0] SLV_BASE = 7'h58;
  localparam logic [7:0] EE_ADDR = 8'hA0;
  localparam logic [5:0] HDR_BYTES = 6'h03;
  localparam logic [5:0] DATA_BYTES = 6'h25;
  localparam logic [5:0] CRC_SPAN = 6'h28;
  localparam logic [9:0] DEV_START = 10'h003;
  localparam logic [9:0] DEV_STRIDE = 10'h026;
  localparam int HDR_CRC_EN_BIT = 7;
  localparam int HDR_MAP_BIT = 6;
  localparam int HDR_BIG_BIT = 5;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // Mode strap level codes; gray along low, float, high
  typedef enum logic [1:0] {
    MODE_PIN = 2'h0,
    MODE_MASTER = 2'h1,
    MODE_SLAVE = 2'h3
  } sel_mode_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ADDR = 3'h1,
    S_ACK = 3'h3,
    S_RX = 3'h2,
    S_TX = 3'h6,
    S_TXACK = 3'h7,
    S_WAIT = 3'h5
  } sel_sstate_t;

  typedef enum logic [1:0] {
    M_WAIT = 2'h0,
    M_RUN = 2'h1,
    M_FIN = 2'h3
  } sel_mstate_t;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_WR = 2'h1,
    OP_RD = 2'h3,
    OP_STOP = 2'h2
  } sel_op_t;

  localparam logic [2:0] OP_LAST = 3'h6;

endpackage

// ==== sel_mgmt.sv ====
// Two-wire management block: SMBus slave register access and EEPROM loader.
// Assumes open-drain pads outside, a free-running link clock and a
// pad comparator coding the mode strap level.

module sel_mgmt
  import sel_pkg::*;
#(
  parameter int NUM_REGS = 37,
  parameter logic [7:0] REG_RESET = 8'h00
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic [1:0] mgmt_mode_strap,
  input wire logic [3:0] addr_strap,
  input wire logic load_enable_in,
  input wire logic smb_scl_in,
  output logic smb_scl_out,
  output logic smb_scl_oe,
  input wire logic smb_sda_in,
  output logic smb_sda_out,
  output logic smb_sda_oe,
  output logic [NUM_REGS-1:0][7:0] cfg_regs,
  output sel_mode_t mgmt_mode,
  output logic load_done_n,
  output logic load_crc_err
);

  if (NUM_REGS < 1 || NUM_REGS > 256)
  begin : g_chk
    $error("NUM_REGS must lie between 1 and 256");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++)
      x = x[7] ? ((x << 1) ^ CRC_POLY) : (x << 1);
    return x;
  endfunction

  function automatic logic [6:0] slave_addr(input logic [3:0] s);
    return SLV_BASE + {3'h0, s};
  endfunction

  function automatic logic [9:0] ee_addr(input logic [5:0] n,
                                         input logic [1:0] idx);
    logic [9:0] base;
    base = DEV_START + 10'(idx) * DEV_STRIDE;
    if (n < HDR_BYTES)
      return {4'h0, n};
    return base + {4'h0, n} - {4'h0, HDR_BYTES};
  endfunction

  function automatic logic [7:0] dev_byte(input logic [9:0] a,
                                          input logic big,
                                          input logic rd);
    return EE_ADDR | {5'h00, big ? a[9:8] : 2'h0, rd};
  endfunction

  function automatic sel_op_t op_kind(input logic [2:0] op);
    case (op)
      3'h0, 3'h3: return OP_START;
      3'h5: return OP_RD;
      3'h6: return OP_STOP;
      default: return OP_WR;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // System domain: mode strap, register file, handshake answer
  // ----------------------------------------------------------------
  logic [1:0] mp1, mp2, mp3;
  logic rq_s1, rq_s2, rq_s3;
  logic sys_ack;
  logic [7:0] sys_rdata;
  logic dn_s1, dn_s2, ce_s1, ce_s2;
  logic m_done, m_crc_err;
  // Link-domain handshake payload, read only after the request edge
  logic ch_req, ch_we;
  logic [7:0] ch_addr, ch_wdata;
  logic rq_edge, rq_hit;

  assign rq_edge = rq_s2 != rq_s3;
  assign rq_hit = {1'b0, ch_addr} < 9'(NUM_REGS);

  // Mode strap filter: a level counts once stages two and three agree
  always_ff @(posedge sys_clk)
  begin
    mp1 <= mgmt_mode_strap;
    mp2 <= mp1;
    mp3 <= mp2;
    if (srst)
      mgmt_mode <= MODE_PIN;
    else if (mp2 == mp3)
      mgmt_mode <= (mp3 == 2'h2) ? MODE_PIN
                                 : sel_mode_t'(mp3); // [RULE23] [RULE11]
  end

  // Request toggle synchroniser
  always_ff @(posedge sys_clk)
  begin
    rq_s1 <= ch_req;
    rq_s2 <= rq_s1;
    rq_s3 <= rq_s2;
  end

  // Register file, cleared at reset and while in pin control
  always_ff @(posedge sys_clk)
  begin
    if (srst || mgmt_mode == MODE_PIN)
      cfg_regs <= {NUM_REGS{REG_RESET}}; // [RULE24]
    else if (rq_edge && ch_we && rq_hit)
      cfg_regs[ch_addr] <= ch_wdata; // [RULE9]
  end

  // Answer: read data and acknowledge toggle
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      {sys_ack, sys_rdata} <= '0;
    else if (rq_edge)
    begin
      sys_ack <= ~sys_ack;
      sys_rdata <= rq_hit ? cfg_regs[ch_addr] : 8'h00; // [RULE10]
    end
  end

  // Load status back from the link domain
  always_ff @(posedge sys_clk)
  begin
    dn_s1 <= m_done;
    dn_s2 <= dn_s1;
    ce_s1 <= m_crc_err;
    ce_s2 <= ce_s1;
    if (srst)
      {load_done_n, load_crc_err} <= 2'h2;
    else
      {load_done_n, load_crc_err} <= {~dn_s2, ce_s2}; // [RULE20]
  end

  // ----------------------------------------------------------------
  // Link domain: synchronisers and bus conditions
  // ----------------------------------------------------------------
  logic lr_s1, lrst;
  logic [1:0] ml_s1;
  sel_mode_t mode_l;
  logic ak_s1, ak_s2, ak_s3;
  logic [2:0] scl_p, sda_p, le_p;
  logic [3:0] ad_p1, ad_p2, ad_p3, ad_f;
  logic scl_f, sda_f, le_f, scl_d, sda_d;
  logic [10:0] idle_cnt;
  logic [7:0] l_rdata;
  logic scl_rise, scl_fall, start_c, stop_c, bus_idle, ch_busy;
  logic s_go, s_we, m_go;

  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign start_c = scl_f & scl_d & sda_d & ~sda_f; // [RULE6]
  assign stop_c = scl_f & scl_d & ~sda_d & sda_f; // [RULE7]
  assign bus_idle = idle_cnt == 11'(IDLE_CYC);
  assign ch_busy = ch_req != ak_s2;

  // Reset, mode and acknowledge crossings
  always_ff @(posedge link_clk)
  begin
    lr_s1 <= srst;
    lrst <= lr_s1;
    ml_s1 <= mgmt_mode;
    mode_l <= sel_mode_t'(ml_s1);
    ak_s1 <= sys_ack;
    ak_s2 <= ak_s1;
    ak_s3 <= ak_s2;
    if (ak_s2 != ak_s3)
      l_rdata <= sys_rdata;
  end

  // Pin filters: a change counts once stages two and three agree
  always_ff @(posedge link_clk)
  begin
    scl_p <= {scl_p[1:0], smb_scl_in};
    sda_p <= {sda_p[1:0], smb_sda_in};
    le_p <= {le_p[1:0], load_enable_in};
    ad_p1 <= addr_strap; // Floating strap reads 0000 via pad pulldown [RULE2]
    ad_p2 <= ad_p1;
    ad_p3 <= ad_p2;
    if (lrst)
    begin
      {scl_f, sda_f, le_f, scl_d, sda_d} <= '1;
      ad_f <= 4'h0;
    end
    else
    begin
      if (scl_p[1] == scl_p[2])
        scl_f <= scl_p[2];
      if (sda_p[1] == sda_p[2])
        sda_f <= sda_p[2];
      if (le_p[1] == le_p[2])
        le_f <= le_p[2];
      if (ad_p2 == ad_p3)
        ad_f <= ad_p3;
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  // Idle timer: both lines high for the idle time
  always_ff @(posedge link_clk)
  begin
    if (lrst || !scl_f || !sda_f)
      idle_cnt <= 11'h000;
    else if (!bus_idle)
      idle_cnt <= idle_cnt + 11'h001; // [RULE8]
  end

  // ----------------------------------------------------------------
  // Slave engine
  // ----------------------------------------------------------------
  sel_sstate_t s_st;
  logic [7:0] s_sh, s_tx, s_ptr;
  logic [3:0] s_bits;
  logic s_rw, s_nbyte1, s_drv;

  always_ff @(posedge link_clk)
  begin
    s_go <= 1'b0;
    if (lrst || mode_l != MODE_SLAVE)
    begin
      s_st <= S_IDLE; // [RULE4]
      s_drv <= 1'b0;
      {s_bits, s_rw, s_we, s_nbyte1} <= '0;
      {s_ptr, s_sh, s_tx} <= '0;
    end
    else if (start_c)
    begin
      s_st <= S_ADDR; // [RULE6]
      s_bits <= 4'h0;
      s_drv <= 1'b0;
    end
    else if (stop_c || bus_idle)
    begin
      s_st <= S_IDLE; // [RULE7] [RULE8]
      s_drv <= 1'b0;
    end
    else
      case (s_st)
        S_ADDR, S_RX:
        begin
          if (scl_rise)
          begin
            s_sh <= {s_sh[6:0], sda_f};
            s_bits <= s_bits + 4'h1;
          end
          else if (scl_fall && s_bits == 4'h8)
          begin
            s_bits <= 4'h0;
            if (s_st == S_ADDR)
            begin
              if (s_sh[7:1] == slave_addr(ad_f)) // [RULE1] [RULE3]
              begin
                s_drv <= 1'b1; // [RULE5] [RULE9]
                s_rw <= s_sh[0];
                s_st <= S_ACK;
                if (!s_sh[0])
                  s_nbyte1 <= 1'b0;
              end
              else
                s_st <= S_WAIT;
            end
            else
            begin
              // First byte is the pointer, also fetched for a later read
              if (!s_nbyte1)
                s_ptr <= s_sh;
              s_we <= s_nbyte1;
              s_nbyte1 <= 1'b1;
              s_go <= 1'b1; // [RULE9] [RULE10]
              s_drv <= 1'b1;
              s_st <= S_ACK;
            end
          end
        end
        S_ACK:
          if (scl_fall)
          begin
            if (s_rw)
            begin
              s_tx <= l_rdata; // [RULE10]
              s_drv <= ~l_rdata[7]; // [RULE5]
              s_bits <= 4'h0;
              s_st <= S_TX;
            end
            else
            begin
              s_drv <= 1'b0;
              s_st <= S_RX;
            end
          end
        S_TX:
          if (scl_fall)
          begin
            s_bits <= s_bits + 4'h1;
            if (s_bits == 4'h7)
            begin
              s_drv <= 1'b0;
              s_st <= S_TXACK;
            end
            else
            begin
              s_tx <= s_tx << 1;
              s_drv <= ~s_tx[6]; // [RULE5]
            end
          end
        S_TXACK:
          if (scl_rise)
            s_st <= sda_f ? S_WAIT : S_ACK; // [RULE10]
        default: s_drv <= 1'b0;
      endcase
  end

  // ----------------------------------------------------------------
  // EEPROM loader (bus master)
  // ----------------------------------------------------------------
  sel_mstate_t m_st;
  logic [3:0] m_div, m_bit;
  logic [1:0] m_q;
  logic [2:0] m_op;
  logic [5:0] m_n;
  logic [7:0] m_sh, m_hdr, m_crc;
  logic m_drv, m_scl_drv, m_nack, m_tick, m_hold;
  logic [9:0] m_ea;
  sel_op_t m_kind;

  assign m_ea = ee_addr(m_n, ad_f[1:0]); // [RULE22]
  assign m_kind = op_kind(m_op);
  assign m_tick = m_div == 4'(EE_QTR_CYC - 1); // [RULE12]
  assign m_hold = m_op == 3'h0 && m_q == 2'h0 && ch_busy;

  always_ff @(posedge link_clk)
  begin
    m_go <= 1'b0;
    if (lrst)
    begin
      m_st <= M_WAIT;
      {m_div, m_bit, m_q, m_op, m_n} <= '0;
      {m_sh, m_hdr} <= '0;
      m_crc <= CRC_INIT;
      {m_drv, m_scl_drv, m_nack, m_done, m_crc_err} <= '0;
    end
    else
      case (m_st)
        M_WAIT:
          if (mode_l == MODE_MASTER && !le_f)
            m_st <= M_RUN; // [RULE11] [RULE19] [RULE21]
        M_RUN:
        begin
          m_div <= m_tick ? 4'h0 : m_div + 4'h1;
          if (m_tick && !m_hold)
          begin
            m_q <= m_q + 2'h1;
            case (m_kind)
              OP_START:
                case (m_q)
                  2'h0: m_drv <= 1'b0;
                  2'h1: m_scl_drv <= 1'b0;
                  2'h2: m_drv <= 1'b1; // [RULE6]
                  default: m_scl_drv <= 1'b1;
                endcase
              OP_STOP:
                case (m_q)
                  2'h0: m_drv <= 1'b1;
                  2'h1: m_scl_drv <= 1'b0;
                  2'h2: m_drv <= 1'b0; // [RULE7]
                  default: m_scl_drv <= m_scl_drv;
                endcase
              default:
                case (m_q)
                  2'h0: m_drv <= (m_kind == OP_WR && m_bit != 4'h8)
                                 ? ~m_sh[7] : 1'b0; // [RULE5]
                  2'h1: m_scl_drv <= 1'b0;
                  2'h2:
                    if (m_bit != 4'h8)
                      m_sh <= {m_sh[6:0], sda_f};
                    else if (m_kind == OP_WR && sda_f)
                      m_nack <= 1'b1;
                  default: m_scl_drv <= 1'b1;
                endcase
            endcase
            // End of an operation
            if (m_q == 2'h3)
            begin
              if (m_kind == OP_START || m_kind == OP_STOP || m_bit == 4'h8)
              begin
                m_bit <= 4'h0;
                m_op <= (m_op == OP_LAST) ? 3'h0 : m_op + 3'h1;
                case (m_op)
                  3'h0: m_sh <= dev_byte(m_ea, m_hdr[HDR_BIG_BIT],
                                         1'b0); // [RULE12] [RULE16]
                  3'h1: m_sh <= m_ea[7:0];
                  3'h3: m_sh <= dev_byte(m_ea, m_hdr[HDR_BIG_BIT], 1'b1);
                  default: m_sh <= m_sh;
                endcase
              end
              else
                m_bit <= m_bit + 4'h1;
            end
            // A byte transfer ended with its stop
            if (m_q == 2'h3 && m_op == OP_LAST)
            begin
              m_nack <= 1'b0;
              if (!m_nack)
              begin
                m_n <= m_n + 6'h01;
                if (m_n == 6'h00)
                  m_hdr <= m_sh; // [RULE13]
                if (m_n < CRC_SPAN)
                  m_crc <= crc8(m_crc, m_sh); // [RULE17]
                if (m_n >= HDR_BYTES && m_n < CRC_SPAN)
                  m_go <= 1'b1; // [RULE14] [RULE15]
                if (m_n == CRC_SPAN)
                begin
                  m_crc_err <= m_hdr[HDR_CRC_EN_BIT] &&
                               m_crc != m_sh; // [RULE18]
                  m_st <= M_FIN;
                end
              end
            end
          end
        end
        default:
        begin
          m_drv <= 1'b0; // [RULE25]
          m_scl_drv <= 1'b0;
          m_done <= 1'b1; // [RULE20]
        end
      endcase
  end

  // ----------------------------------------------------------------
  // Request channel and pad drivers
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk)
  begin
    if (lrst)
      {ch_req, ch_we, ch_addr, ch_wdata} <= '0;
    else if (s_go)
    begin
      ch_req <= ~ch_req;
      ch_we <= s_we;
      ch_addr <= s_ptr;
      ch_wdata <= s_sh;
    end
    else if (m_go)
    begin
      ch_req <= ~ch_req;
      ch_we <= 1'b1;
      ch_addr <= {2'h0, m_n - 6'h01 - HDR_BYTES};
      ch_wdata <= m_sh;
    end
  end

  // Open-drain pads: only ever pull low
  always_ff @(posedge link_clk)
  begin
    {smb_scl_out, smb_sda_out} <= 2'h0;
    if (lrst)
      {smb_scl_oe, smb_sda_oe} <= 2'h0;
    else
    begin
      smb_scl_oe <= m_scl_drv;
      smb_sda_oe <= s_drv | m_drv;
    end
  end

endmodule

// ==== sel_mgmt_asserts.sv ====
// Checker for the two-wire management block, bound to its top module.
// Assumes it sees only top-level ports; bus lines resolved outside.
module sel_mgmt_asserts
  import sel_pkg::*;
#(
  parameter int NUM_REGS = 37,
  parameter logic [7:0] REG_RESET = 8'h00
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic [1:0] mgmt_mode_strap,
  input wire logic load_enable_in,
  input wire logic smb_scl_in,
  input wire logic smb_scl_oe,
  input wire logic smb_sda_oe,
  input wire logic [NUM_REGS-1:0][7:0] cfg_regs,
  input wire sel_mode_t mgmt_mode,
  input wire logic load_done_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic en_seen;

  // Remembers the chain enable seen low since reset
  always_ff @(posedge link_clk)
  begin
    if (srst)
      en_seen <= 1'b0;
    else if (!load_enable_in)
      en_seen <= 1'b1;
  end

  // --------------------
  // Link domain
  // --------------------
  AST_SLV_SDA_STEADY:
    assert property (@(posedge link_clk) disable iff (srst)
      mgmt_mode == MODE_SLAVE && $changed(smb_sda_oe) |-> !smb_scl_in)
    else $error("slave data moved while clock high");
  AST_WAIT_LOAD_EN:
    assert property (@(posedge link_clk) disable iff (srst)
      mgmt_mode == MODE_MASTER && !en_seen |-> !smb_scl_oe && !smb_sda_oe)
    else $error("master used bus before enable");
  AST_MST_START:
    assert property (@(posedge link_clk) disable iff (srst)
      mgmt_mode == MODE_MASTER && $rose(smb_sda_oe) && smb_scl_in
      |-> ##[1:16] smb_scl_oe)
    else $error("no clock after master start");
  AST_MST_STOP:
    assert property (@(posedge link_clk) disable iff (srst)
      mgmt_mode == MODE_MASTER && $fell(smb_sda_oe) && smb_scl_in
      |=> !smb_scl_oe [*4])
    else $error("clock pulled right after stop");
  AST_MST_SCL_LOW:
    assert property (@(posedge link_clk) disable iff (srst)
      mgmt_mode == MODE_MASTER && $rose(smb_scl_oe) |=> smb_scl_oe [*7])
    else $error("master clock low phase too short");
  AST_RELEASED_AFTER:
    assert property (@(posedge link_clk) disable iff (srst)
      !load_done_n |-> !smb_scl_oe && !smb_sda_oe)
    else $error("bus held after load done");

  // --------------------
  // System domain
  // --------------------
  AST_PIN_QUIET:
    assert property (@(posedge sys_clk) disable iff (srst)
      mgmt_mode == MODE_PIN |-> !smb_scl_oe && !smb_sda_oe)
    else $error("bus driven in pin mode");
  AST_MODE_SLAVE:
    assert property (@(posedge sys_clk) disable iff (srst)
      (mgmt_mode_strap == 2'h3) [*8] |-> mgmt_mode == MODE_SLAVE)
    else $error("high strap not slave");
  AST_MODE_MASTER:
    assert property (@(posedge sys_clk) disable iff (srst)
      (mgmt_mode_strap == 2'h1) [*8] |-> mgmt_mode == MODE_MASTER)
    else $error("floating strap not master");
  AST_MODE_PIN:
    assert property (@(posedge sys_clk) disable iff (srst)
      (mgmt_mode_strap == 2'h0) [*8] |-> mgmt_mode == MODE_PIN)
    else $error("low strap not pin mode");
  AST_REG_DEFAULT:
    assert property (@(posedge sys_clk) disable iff (srst)
      mgmt_mode == MODE_PIN [*3] |-> cfg_regs == {NUM_REGS{REG_RESET}})
    else $error("registers not at default in pin mode");
  AST_DONE_STANDS:
    assert property (@(posedge sys_clk) disable iff (srst)
      $fell(load_done_n) |=> !load_done_n [*8])
    else $error("done did not stay low");
endmodule

bind sel_mgmt sel_mgmt_asserts #(.NUM_REGS(NUM_REGS), .REG_RESET(REG_RESET))
  sel_mgmt_asserts_i (.sys_clk(sys_clk), .srst(srst), .link_clk(link_clk),
  .mgmt_mode_strap(mgmt_mode_strap), .load_enable_in(load_enable_in),
  .smb_scl_in(smb_scl_in), .smb_scl_oe(smb_scl_oe),
  .smb_sda_oe(smb_sda_oe), .cfg_regs(cfg_regs), .mgmt_mode(mgmt_mode),
  .load_done_n(load_done_n));

// ==== sel_eeprom_model.sv ====
// Serial EEPROM partner: open-drain two-wire slave with 256 bytes.
// Assumes resolved lines that read high when nobody pulls them.
module sel_eeprom_model
#(
  parameter logic [7:0] DEV_ADDR = 8'hA0,
  parameter int RESP_NS = 40
)
(
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [256];
  logic [7:0] sh, ptr;
  logic act = 1'b0;
  logic snd, got_dev, nack;
  int cnt;

  initial sda_oe = 1'b0;

  // Start and stop detection
  always @(negedge sda)
    if (scl)
      {act, snd, got_dev, cnt} = {3'b100, -32'sd1};
  always @(posedge sda)
    if (scl)
      act = 1'b0;

  // Samples host bits and the host acknowledge
  always @(posedge scl)
  begin
    if (act && !snd && cnt < 8)
      sh = {sh[6:0], sda};
    if (act && snd && cnt == 8)
      nack = sda;
  end

  // Drives data only while the clock is low
  always @(negedge scl)
  begin
    if (act && cnt < 8)
    begin
      cnt++;
      if (snd)
        sda_oe <= #(RESP_NS) (cnt < 8) && !sh[7 - cnt];
      else if (cnt == 8)
      begin
        act = got_dev || sh[7:1] == DEV_ADDR[7:1];
        if (got_dev)
          ptr = sh;
        else
          snd = sh[0];
        got_dev = 1'b1;
        sda_oe <= #(RESP_NS) act;
      end
    end
    else if (act)
    begin
      cnt = 0;
      sh = mem[ptr];
      act = !(snd && nack);
      if (snd && act)
        ptr++;
      sda_oe <= #(RESP_NS) snd && act && !sh[7];
    end
  end
endmodule

// ==== tb_top.sv ====
// Bench: EEPROM load as master, then host access as slave, then pin mode.
// Assumes pull-ups on both lines, modelled by the wired resolution.
module tb_top
  import sel_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int NR = 37;
  logic sys_clk, srst, link_clk, load_enable_in, h_scl, h_sda;
  logic ee_sda_oe, smb_scl_out, smb_scl_oe, smb_sda_out, smb_sda_oe;
  logic load_done_n, load_crc_err, scl_w, sda_w;
  logic [1:0] mgmt_mode_strap;
  logic [3:0] addr_strap;
  logic [NR-1:0][7:0] cfg_regs;
  sel_mode_t mgmt_mode;
  logic [7:0] img [256];
  logic [7:0] rb;
  logic [2:0] ak;
  int miscompares = 0, checked = 0, cyc = 0;

  // --------------------
  // Clocks and wiring
  // --------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = !sys_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = !link_clk;
  end
  // Open-drain lines: low while any party pulls
  assign scl_w = !(h_scl || smb_scl_oe);
  assign sda_w = !(h_sda || smb_sda_oe || ee_sda_oe);

  sel_mgmt #(.NUM_REGS(NR), .REG_RESET(8'h00)) sel_mgmt_i (
    .sys_clk(sys_clk), .srst(srst), .link_clk(link_clk),
    .mgmt_mode_strap(mgmt_mode_strap), .addr_strap(addr_strap),
    .load_enable_in(load_enable_in), .smb_scl_in(scl_w),
    .smb_scl_out(smb_scl_out), .smb_scl_oe(smb_scl_oe),
    .smb_sda_in(sda_w), .smb_sda_out(smb_sda_out),
    .smb_sda_oe(smb_sda_oe), .cfg_regs(cfg_regs), .mgmt_mode(mgmt_mode),
    .load_done_n(load_done_n), .load_crc_err(load_crc_err));
  sel_eeprom_model #(.RESP_NS(150)) sel_eeprom_model_i (
    .scl(scl_w), .sda(sda_w), .sda_oe(ee_sda_oe));

  // --------------------
  // Tasks
  // --------------------
  function automatic logic [7:0] pat(input int i);
    return 8'(i * 29) ^ 8'hA5;
  endfunction
  function automatic logic [7:0] crc8(input logic [7:0] c, d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++)
      x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    return x;
  endfunction
  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk_b(input string n, input logic [7:0] e, g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic ph();
    repeat (14) @(posedge sys_clk);
  endtask
  task automatic bit_x(input logic b, output logic r);
    h_sda <= !b;
    ph();
    h_scl <= 1'b0;
    ph();
    r = sda_w;
    h_scl <= 1'b1;
    ph();
  endtask
  task automatic start_c();
    h_sda <= 1'b0;
    ph();
    h_scl <= 1'b0;
    ph();
    h_sda <= 1'b1;
    ph();
    h_scl <= 1'b1;
    ph();
  endtask
  task automatic stop_c();
    h_sda <= 1'b1;
    ph();
    h_scl <= 1'b0;
    ph();
    h_sda <= 1'b0;
    ph();
  endtask
  task automatic send(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    a = !r;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, d);
    start_c();
    send({a, 1'b0}, ak[2]);
    send(p, ak[1]);
    send(d, ak[0]);
    stop_c();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p);
    logic r;
    start_c();
    send({a, 1'b0}, ak[2]);
    send(p, ak[1]);
    start_c();
    send({a, 1'b1}, ak[0]);
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, rb[i]);
    bit_x(1'b1, r);
    stop_c();
  endtask

  // Ends a hung run
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 99000)
    begin
      miscompares++;
      end_sim();
    end
  end

  // --------------------
  // Tests
  // --------------------
  initial
  begin
    logic [7:0] c;
    {srst, load_enable_in, h_scl, h_sda} = 4'h C;
    mgmt_mode_strap = 2'h1;
    addr_strap = 4'h1;
    c = 8'h00;
    for (int i = 0; i < 256; i++)
      img[i] = pat(i);
    {img[0], img[1], img[2]} = {8'h80, 8'h00, 8'h00};
    for (int i = 0; i < 40; i++)
      c = crc8(c, img[i < 3 ? i : i + 38]);
    img[78] = c;
    sel_eeprom_model_i.mem = img;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (300) @(posedge sys_clk);
    chk_b("idle_done", 8'h1, {7'h0, load_done_n});
    chk_b("idle_scl", 8'h1, {7'h0, scl_w});
    load_enable_in <= 1'b0;
    for (int i = 0; i < 95000 && load_done_n !== 1'b0; i++)
      @(posedge sys_clk);
    repeat (10) @(posedge sys_clk);
    chk_b("done", 8'h0, {7'h0, load_done_n});
    for (int k = 0; k < NR; k++)
      chk_b("cfg", pat(41 + k), cfg_regs[k]);
    chk_b("crc_err", 8'h0, {7'h0, load_crc_err});
    chk_b("lines", 8'h3,
          {4'h0, smb_scl_out, smb_sda_out, scl_w, sda_w});
    $display("test eeprom load done");
    srst <= 1'b1;
    mgmt_mode_strap <= 2'h3;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (40) @(posedge sys_clk);
    chk_b("mode", {6'h0, MODE_SLAVE}, {6'h0, mgmt_mode});
    for (int s = 0; s < 16; s += 15)
    begin
      addr_strap <= 4'(s);
      repeat (20) @(posedge sys_clk);
      wr(7'h58 + 7'(s), 8'h05, 8'h3C + 8'(s));
      chk_b("wr_ack", 8'h7, {5'h0, ak});
      chk_b("reg5", 8'h3C + 8'(s), cfg_regs[5]);
      rd(7'h58 + 7'(s), 8'h05);
      chk_b("rd_ack", 8'h7, {5'h0, ak});
      chk_b("rd_data", 8'h3C + 8'(s), rb);
    end
    wr(7'h58, 8'h05, 8'hEE);
    chk_b("wrong_ack", 8'h0, {5'h0, ak});
    chk_b("reg5_kept", 8'h4B, cfg_regs[5]);
    $display("test slave access done");
    mgmt_mode_strap <= 2'h0;
    repeat (20) @(posedge sys_clk);
    chk_b("mode", {6'h0, MODE_PIN}, {6'h0, mgmt_mode});
    chk_b("reg5_pin", 8'h00, cfg_regs[5]);
    wr(7'h67, 8'h05, 8'h11);
    chk_b("pin_ack", 8'h0, {5'h0, ak});
    chk_b("reg5_pin", 8'h00, cfg_regs[5]);
    $display("test pin mode done");
    end_sim();
  end
endmodule
